// ===== verilog/scb_spi.v
// spi port: registers, baud select, transmit queue and shift engine
//
// Overview of operation
// [R1] software uses whole-word register accesses only
// [R2] software enables peripheral clock before register writes
// [R3] bits 15:13 select master clock rate
// [R4] rate select resets to binary 011
// [R5] serial rate is bus clock over divisor
// [R6] normal range divisors run 2 to 256
// [R7] extended range divisors 512 to 16384
// [R8] doubling bit doubles divisor, except top codes
// [R9] bit 12 picks msb or lsb first
// [R10] data stays right-justified, upper bits zero
// [R11] remote party uses same length and order
// [R12] error interrupt on overflow or enabled mode fault
// [R13] software keeps serial rate within pad limits
// [R14] software avoids read-modify-write on status/control
// [R15] bit 8 picks master or slave role; no slave mode here, a clear bit 8 leaves the port idle
// [R16] divisor counter restarts at each transaction
`timescale 1ns/1ps
`include "scb_consts.vh"
module scb_spi (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // register port
  input  wire [31:0] reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata_q,
  output reg         tx_space_q,
  // serial pins
  output reg         sclk_out_q,
  output reg         sclk_oe_q,
  output reg         mosi_out_q,
  output reg         mosi_oe_q,
  input  wire        miso_in,
  input  wire        ss_n_in,
  // interrupt request
  output reg         err_irq_q
);
  // =====================================================
  // states
  localparam ST_IDLE  = 2'b00;
  localparam ST_SHIFT = 2'b01;
  localparam ST_DONE  = 2'b10;

  reg  [15:0] scr_q;        // control part of status/control
  reg  [15:0] size_q;       // size/control register
  reg  [15:0] qctl_q;       // queue control register
  reg  [15:0] wait_q;       // word delay register
  reg  [15:0] rx_q;         // receive data register
  reg         rx_full_q;    // receive register holds unread word
  reg         ovr_q;        // overflow_flag
  reg         mode_fault_flag_q;       // mode_fault_flag
  reg  [1:0]  state_q;      // engine state
  reg  [15:0] tx_q;         // word being sent
  reg  [15:0] rxacc_q;      // word being received
  reg  [4:0]  bit_cnt_q;    // bits sampled so far
  reg  [4:0]  edge_q;       // serial clock edges so far
  reg  [15:0] gap_q;        // remaining word delay

  // =====================================================
  // field views
  wire [2:0] rate_select_code =
    scr_q[`SCB_F_RATE_HI:`SCB_F_RATE_LO];           // [R3]
  wire shift_order_bit          = scr_q[`SCB_F_ORDER];
  wire error_irq_enable         = scr_q[`SCB_F_ERROR_IRQ_ENABLE];
  wire mode_fault_detect_enable = scr_q[`SCB_F_MFEN];
  wire master_role_bit          = scr_q[`SCB_F_MASTER];
  wire cpol                     = scr_q[`SCB_F_CPOL];
  wire cpha                     = scr_q[`SCB_F_CPHA];
  wire spe                      = scr_q[`SCB_F_ENABLE];
  wire extended_range_bit       = size_q[`SCB_F_EXT];
  wire divisor_double_bit       = size_q[`SCB_F_DBL];
  wire [3:0] len_fld = size_q[`SCB_F_LEN_HI:`SCB_F_LEN_LO];
  // word length 2..16, a zero field counts as 2
  wire [4:0] len = (len_fld == 4'h0) ? 5'h2 : {1'b0, len_fld} + 5'h1;

  // =====================================================
  // register decode
  wire wr_scr  = reg_wr && (reg_addr == `SCB_A_SCR);
  wire wr_size = reg_wr && (reg_addr == `SCB_A_SIZE);
  wire wr_txd  = reg_wr && (reg_addr == `SCB_A_TXD);
  wire wr_qctl = reg_wr && (reg_addr == `SCB_A_QCTL);
  wire wr_wait = reg_wr && (reg_addr == `SCB_A_WAIT);
  wire rd_rxd  = reg_rd && (reg_addr == `SCB_A_RXD);

  // =====================================================
  // bit position of the n-th bit on the wire
  function [3:0] wire_idx;
    input [4:0] n;
    input [4:0] l;
    input       lsb_first;
    reg   [4:0] t;
    begin
      t = l - 5'h1 - n;
      wire_idx = lsb_first ? n[3:0] : t[3:0];       // [R9]
    end
  endfunction

  // =====================================================
  // transmit queue
  wire        txq_ready;
  wire        txq_valid;
  wire [15:0] txq_data;
  wire        flush = wr_qctl && reg_wdata[`SCB_F_FLUSH];
  wire        master_on = spe && master_role_bit;    // [R15]
  wire        start = (state_q == ST_IDLE) && master_on && !mode_fault_flag_q &&
                      txq_valid && (gap_q == `SCB_RST_ZERO);
  scb_fifo #(
    .W  (`SCB_TXQ_W),
    .D  (`SCB_TXQ_D),
    .AW (`SCB_TXQ_AW)
  ) u_txq (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .flush     (flush),
    .in_valid  (wr_txd),
    .in_ready  (txq_ready),
    .in_data   (reg_wdata),
    .out_valid (txq_valid),
    .out_ready (start),
    .out_data  (txq_data)
  );

  // =====================================================
  // baud tick, running only while shifting
  wire tick;
  scb_baud u_baud (
    .clk_sys            (clk_sys),
    .rst_n              (rst_n),
    .run                (state_q == ST_SHIFT),
    .rate_select_code   (rate_select_code),
    .extended_range_bit (extended_range_bit),
    .divisor_double_bit (divisor_double_bit),
    .tick               (tick)
  );

  // =====================================================
  // edge classification
  wire leading  = ~edge_q[0];
  wire samp_edg = cpha ? ~leading : leading;
  wire last_edg = (edge_q == {len[3:0], 1'b0} - 5'h1);
  // mode fault: another master pulls select low
  wire mode_fault_flag_set = master_on && mode_fault_detect_enable && !ss_n_in;
  wire abort    = mode_fault_flag_set && (state_q == ST_SHIFT);
  wire ovr_set  = (state_q == ST_DONE) && rx_full_q;
  wire w1c_mode_fault_flag = wr_scr && reg_wdata[`SCB_F_MODE_FAULT_FLAG];
  wire w1c_ovr  = wr_scr && reg_wdata[`SCB_F_OVR];

  // =====================================================
  // configuration registers
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      scr_q  <= `SCB_RST_SCR;                       // [R4]
      size_q <= `SCB_RST_SIZE;
      qctl_q <= `SCB_RST_QCTL;
      wait_q <= `SCB_RST_ZERO;
    end else begin
      if (wr_scr) begin
        scr_q <= reg_wdata;
      end
      if (wr_size) begin
        size_q <= reg_wdata;
      end
      if (wr_qctl) begin
        qctl_q <= reg_wdata;
      end
      if (wr_wait) begin
        wait_q <= reg_wdata;
      end
    end
  end

  // =====================================================
  // sticky flags, a set in the clearing cycle wins
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ovr_q     <= 1'b0;
      mode_fault_flag_q    <= 1'b0;
      rx_full_q <= 1'b0;
    end else begin
      ovr_q  <= ovr_set | (ovr_q & ~w1c_ovr);
      mode_fault_flag_q <= mode_fault_flag_set | (mode_fault_flag_q & ~w1c_mode_fault_flag);
      rx_full_q <= (state_q == ST_DONE) | (rx_full_q & ~rd_rxd);
    end
  end

  // =====================================================
  // shift engine
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      tx_q      <= `SCB_RST_ZERO;
      rxacc_q   <= `SCB_RST_ZERO;
      rx_q      <= `SCB_RST_ZERO;
      bit_cnt_q <= 5'h0;
      edge_q    <= 5'h0;
      gap_q     <= `SCB_RST_ZERO;
      sclk_out_q <= 1'b0;
      mosi_out_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          sclk_out_q <= cpol;
          if (gap_q != `SCB_RST_ZERO) begin
            gap_q <= gap_q - 16'h1;
          end
          if (start) begin
            tx_q      <= txq_data;
            rxacc_q   <= `SCB_RST_ZERO;              // [R10]
            bit_cnt_q <= 5'h0;
            edge_q    <= 5'h0;
            state_q   <= ST_SHIFT;
            if (!cpha) begin
              mosi_out_q <= txq_data[wire_idx(5'h0, len,
                                     shift_order_bit)];
            end
          end
        end
        ST_SHIFT: begin
          if (abort) begin
            state_q <= ST_IDLE;
            sclk_out_q <= cpol;
          end else if (tick) begin
            // the pin itself toggles here, so data launch and sample
            // line up with the edge the far side sees
            sclk_out_q <= ~sclk_out_q;
            edge_q <= edge_q + 5'h1;
            if (samp_edg) begin
              rxacc_q[wire_idx(bit_cnt_q, len, shift_order_bit)]
                <= miso_in;                         // [R9] [R10]
              bit_cnt_q <= bit_cnt_q + 5'h1;
            end else if (bit_cnt_q < len) begin
              mosi_out_q <= tx_q[wire_idx(bit_cnt_q, len,
                                 shift_order_bit)]; // [R9]
            end
            if (last_edg) begin
              state_q <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          rx_q    <= rxacc_q;                       // [R10]
          gap_q   <= wait_q;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // =====================================================
  // pin drivers, master drives clock and data
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sclk_oe_q  <= 1'b0;
      mosi_oe_q  <= 1'b0;
    end else begin
      sclk_oe_q  <= master_on && !mode_fault_flag_q;           // [R15]
      mosi_oe_q  <= master_on && !mode_fault_flag_q;           // [R15]
    end
  end

  // =====================================================
  // error interrupt request
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      err_irq_q <= 1'b0;
    end else begin
      err_irq_q <= error_irq_enable &&
                   (ovr_q || (mode_fault_flag_q && mode_fault_detect_enable)); // [R12]
    end
  end

  // =====================================================
  // read data, registered one cycle after the strobe
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata_q <= `SCB_RST_ZERO;
      tx_space_q  <= 1'b0;
    end else begin
      tx_space_q <= txq_ready;
      reg_rdata_q <= `SCB_RST_ZERO;
      if (reg_rd) begin
        case (reg_addr)
          `SCB_A_SCR: begin
            reg_rdata_q <= {scr_q[15:6], mode_fault_flag_q, rx_full_q, ovr_q,
                            state_q != ST_IDLE, spe, !txq_valid};
          end
          `SCB_A_SIZE: begin
            reg_rdata_q <= size_q;
          end
          `SCB_A_RXD: begin
            reg_rdata_q <= rx_q;                    // [R10]
          end
          `SCB_A_QCTL: begin
            reg_rdata_q <= qctl_q;
          end
          `SCB_A_WAIT: begin
            reg_rdata_q <= wait_q;
          end
          default: begin
            reg_rdata_q <= `SCB_RST_ZERO;
          end
        endcase
      end
    end
  end
endmodule // scb_spi

// ===== verilog/scb_consts.vh
// constants for the spi baud select and control block
`ifndef SCB_CONSTS_VH
`define SCB_CONSTS_VH
// =====================================================
// register addresses
`define SCB_A_SCR    32'hFFFFEC80
`define SCB_A_SIZE   32'hFFFFEC82
`define SCB_A_RXD    32'hFFFFEC84
`define SCB_A_TXD    32'hFFFFEC86
`define SCB_A_QCTL   32'hFFFFEC88
`define SCB_A_WAIT   32'hFFFFEC8A
// =====================================================
// reset values
`define SCB_RST_SCR  16'h6141
`define SCB_RST_SIZE 16'h000F
`define SCB_RST_QCTL 16'h000C
`define SCB_RST_ZERO 16'h0000
`define SCB_RST_RATE 3'h3
// =====================================================
// status/control field positions
`define SCB_F_RATE_HI 15
`define SCB_F_RATE_LO 13
`define SCB_F_ORDER   12
`define SCB_F_ERROR_IRQ_ENABLE   11
`define SCB_F_MFEN    10
`define SCB_F_RXIE    9
`define SCB_F_MASTER  8
`define SCB_F_CPOL    7
`define SCB_F_CPHA    6
`define SCB_F_MODE_FAULT_FLAG    5
`define SCB_F_RXFULL  4
`define SCB_F_OVR     3
`define SCB_F_BUSY    2
`define SCB_F_ENABLE  1
`define SCB_F_TXEMPTY 0
// =====================================================
// size/control and queue control field positions
`define SCB_F_LEN_HI  3
`define SCB_F_LEN_LO  0
`define SCB_F_EXT     4
`define SCB_F_DBL     5
`define SCB_F_FLUSH   0
// =====================================================
// transmit queue shape
`define SCB_TXQ_W     16
`define SCB_TXQ_D     32
`define SCB_TXQ_AW    5
`endif

// ===== verilog/scb_fifo.v
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module scb_fifo #(
  parameter W  = 16,
  parameter D  = 32,
  parameter AW = 5
) (
  // clock and reset
  input  wire         clk_sys,
  input  wire         rst_n,
  input  wire         flush,
  // fill side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // drain side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_q [0:D-1]; // storage
  reg [AW-1:0] wr_q;          // write pointer
  reg [AW-1:0] rd_q;          // read pointer
  reg [AW:0]   cnt_q;         // fill level
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  assign in_ready  = (cnt_q != D[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_q];
  // =====================================================
  // storage write
  always @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  // =====================================================
  // pointers and level
  always @(posedge clk_sys) begin
    if (!rst_n || flush) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // scb_fifo

// ===== verilog/scb_baud.v
// serial clock half-period tick generator
`timescale 1ns/1ps
module scb_baud (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // control
  input  wire       run,
  input  wire [2:0] rate_select_code,
  input  wire       extended_range_bit,
  input  wire       divisor_double_bit,
  // half-period tick
  output wire       tick
);
  reg  [13:0] cnt_q;  // half-period counter
  wire [3:0]  hexp;   // log2 of half divisor
  wire [13:0] limit;  // last count of a half period
  // =====================================================
  // log2 of half the rate divisor
  function [3:0] half_exp;
    input [2:0] code;
    input       ext;
    input       dbl;
    reg   [3:0] e;
    begin
      e = 4'h0;
      if (!ext) begin
        e = {1'b0, code};                           // [R6]
      end else if (code <= 3'h4) begin
        e = {1'b0, code} + 4'h8;                    // [R7]
      end else begin
        e = 4'hD;                                   // [R7]
      end
      if (dbl && !(ext && code >= 3'h5)) begin
        e = e + 4'h1;                               // [R8]
      end
      half_exp = e;
    end
  endfunction
  assign hexp  = half_exp(rate_select_code, extended_range_bit,
                          divisor_double_bit);
  assign limit = (14'h1 << hexp) - 14'h1;           // [R5]
  assign tick  = run && (cnt_q == limit);
  // =====================================================
  // counter, held at zero while idle
  always @(posedge clk_sys) begin
    if (!rst_n || !run) begin
      cnt_q <= 14'h0;                               // [R16]
    end else if (tick) begin
      cnt_q <= 14'h0;
    end else begin
      cnt_q <= cnt_q + 14'h1;
    end
  end
endmodule // scb_baud

// ===== tb/scb_spi_monitor.sv
// checker for the spi control and baud select port pins
`timescale 1ns/1ps
`include "scb_consts.vh"
module scb_spi_monitor (
  // clock and reset
  input wire        clk_sys,
  input wire        rst_n,
  // register port
  input wire [31:0] reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata_q,
  input wire        tx_space_q,
  // serial pins and request
  input wire        sclk_out_q,
  input wire        sclk_oe_q,
  input wire        mosi_out_q,
  input wire        mosi_oe_q,
  input wire        miso_in,
  input wire        ss_n_in,
  input wire        err_irq_q
);
  // ==================================================
  // helpers
  reg  [15:0] wd1_q; // write data one cycle back
  reg  [15:0] wd2_q; // write data two cycles back
  wire        hit;   // address is one of the six registers
  assign hit = reg_addr[31:4] == 28'hFFFFEC8 && !reg_addr[0]
    && reg_addr[3:0] <= 4'hA;
  // delay line for the read-back checks
  always @(posedge clk_sys) begin
    wd1_q <= reg_wdata;
    wd2_q <= wd1_q;
  end
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==================================================
  // assertions
  reset_clear_a: assert property (!$past(rst_n) |->
    !sclk_oe_q && !err_irq_q && reg_rdata_q == 16'h0000)
    else $error("outputs not cleared by reset");
  oe_pair_a: assert property (mosi_oe_q == sclk_oe_q)
    else $error("data and clock enables differ");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata_q == 16'h0000)
    else $error("read data outside a read");
  unmapped_zero_a: assert property (reg_rd && !hit |=>
    reg_rdata_q == 16'h0000) else $error("unmapped read not zero");
  sclk_quiet_a: assert property (!sclk_oe_q && !$past(sclk_oe_q)
    && !$past(sclk_oe_q, 2) && !$past(reg_wr) && !$past(reg_wr, 2)
    |-> $stable(sclk_out_q)) else $error("serial clock moved while idle");
  scr_back_a: assert property (reg_wr && reg_addr == `SCB_A_SCR ##1
    reg_rd && reg_addr == `SCB_A_SCR |=> reg_rdata_q[15:6] == wd2_q[15:6])
    else $error("control bits not read back");
  size_back_a: assert property (reg_wr && reg_addr == `SCB_A_SIZE ##1
    reg_rd && reg_addr == `SCB_A_SIZE |=> reg_rdata_q[5:0] == wd2_q[5:0])
    else $error("size bits not read back");
  wait_back_a: assert property (reg_wr && reg_addr == `SCB_A_WAIT ##1
    reg_rd && reg_addr == `SCB_A_WAIT |=> reg_rdata_q == wd2_q)
    else $error("word delay not read back");
endmodule // scb_spi_monitor
bind scb_spi scb_spi_monitor u_mon (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
  .tx_space_q(tx_space_q), .sclk_out_q(sclk_out_q), .sclk_oe_q(sclk_oe_q),
  .mosi_out_q(mosi_out_q), .mosi_oe_q(mosi_oe_q), .miso_in(miso_in),
  .ss_n_in(ss_n_in), .err_irq_q(err_irq_q));

// ===== tb/scb_spi_partner.sv
// behavioural spi slave standing on the far side of the port
`timescale 1ns/1ps
module scb_spi_partner (
  // serial pins
  input  wire        sclk,
  input  wire        mosi,
  output reg         miso,
  // frame setup, any change of load restarts
  input  wire        load,
  input  wire        lsb_first,
  input  wire        cpha,
  input  wire [4:0]  len,
  input  wire [15:0] tx_word,
  // word taken from the master
  output reg  [15:0] rx_word
);
  integer on; // bits sent
  integer nn; // bits taken
  initial begin
    miso = 1'b0;
    on = 0;
    nn = 0;
  end
  // next bit out in the agreed length and order
  task drive;
    begin
      miso = tx_word[lsb_first ? on % len : len - 1 - on % len];
      on = on + 1;
    end
  endtask
  // take the master's bit
  task take;
    begin
      rx_word[lsb_first ? nn % len : len - 1 - nn % len] = mosi;
      nn = nn + 1;
    end
  endtask
  // restart, line parked on the inverse of its last level;
  // early phase presents the first bit before any edge
  always @(load) begin
    on = 0;
    nn = 0;
    rx_word = 16'h0000;
    miso = ~miso;
    if (!cpha) begin
      drive;
    end
  end
  // leading edge: late phase drives, early phase takes
  always @(posedge sclk) begin
    if (cpha) begin
      drive;
    end else begin
      take;
    end
  end
  // trailing edge: late phase takes, early phase drives
  always @(negedge sclk) begin
    if (cpha) begin
      take;
    end else begin
      drive;
    end
  end
endmodule // scb_spi_partner

// ===== tb/spi_control_baud_select_tb_top.sv
// self-checking bench for the spi control and baud select block
`timescale 1ns/1ps
`include "scb_consts.vh"
module spi_control_baud_select_tb_top;
  // design drive
  reg         clk_sys;
  reg         rst_n;
  reg  [31:0] reg_addr;
  reg         reg_wr;
  reg         reg_rd;
  reg  [15:0] reg_wdata;
  reg         ss_n_in;
  // design outputs
  wire [15:0] reg_rdata_q;
  wire        tx_space_q;
  wire        sclk_out_q;
  wire        sclk_oe_q;
  wire        mosi_out_q;
  wire        mosi_oe_q;
  wire        miso;
  wire        err_irq_q;
  // far side setup and capture
  reg         p_load;
  reg         p_lsb;
  reg         p_cpha;
  reg  [4:0]  p_len;
  reg  [15:0] p_tx;
  wire [15:0] far_rx;
  // bench state
  reg  [31:0] seed;
  reg  [15:0] rd_v;
  reg  [15:0] w;
  reg  [4:0]  cs;
  integer     fail_count;
  integer     comparisons;
  integer     i;
  integer     n;
  scb_spi dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .tx_space_q(tx_space_q), .sclk_out_q(sclk_out_q), .sclk_oe_q(sclk_oe_q),
    .mosi_out_q(mosi_out_q), .mosi_oe_q(mosi_oe_q), .miso_in(miso),
    .ss_n_in(ss_n_in), .err_irq_q(err_irq_q));
  scb_spi_partner far (
    .sclk(sclk_out_q), .mosi(mosi_out_q), .miso(miso), .load(p_load),
    .lsb_first(p_lsb), .cpha(p_cpha), .len(p_len), .tx_word(p_tx),
    .rx_word(far_rx));
  // 25 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // ==================================================
  // expectations and helpers
  function automatic [31:0] xs(input [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // divisor for a code and the extended and doubling bits
  function automatic integer bd(input [2:0] c, input e, input d);
    integer b;
    b = e ? (c > 3'h4 ? 16384 : 512 << c) : 2 << c;
    if (d && !(e && c > 3'h4)) b = b * 2;
    return b;
  endfunction
  // mask of a word length
  function automatic [15:0] mk(input [4:0] l);
    return 16'hFFFF >> (5'h10 - l);
  endfunction
  task automatic chk(input [15:0] got, input [15:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (fail_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic bail;
    fail_count = fail_count + 1;
    final_report;
  endtask
  task automatic wr(input [31:0] a, input [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input [31:0] a, output [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata_q;
  endtask
  // write, read straight back, compare the stored bits
  task automatic wr_back(input [31:0] a, input [15:0] d, input [15:0] m);
    wr(a, d);
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata_q & m, d & m);
  endtask
  // cycles until the serial clock next changes
  task automatic wait_sclk(output integer c);
    reg s;
    s = sclk_out_q;
    c = 0;
    while (sclk_out_q === s) begin
      @(negedge clk_sys);
      c = c + 1;
      if (c > 20000) bail;
    end
  endtask
  // poll one status bit for a level
  task automatic wait_scr(input integer b, input v);
    n = 0;
    rd(`SCB_A_SCR, rd_v);
    while (rd_v[b] !== v) begin
      n = n + 1;
      if (n > 3000) bail;
      rd(`SCB_A_SCR, rd_v);
    end
  endtask
  // ==================================================
  // main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, p_load, p_lsb, p_cpha} = 6'h00;
    reg_addr = 32'h00000000;
    reg_wdata = 16'h0000;
    ss_n_in = 1'b1;
    p_len = 5'h10;
    p_tx = 16'h0000;
    seed = 32'h0000000C;
    fail_count = 0;
    comparisons = 0;
    repeat (4) @(posedge clk_sys);
    // the block's clock gate counts as open from here on
    rst_n <= 1'b1;
    rd(`SCB_A_SCR, rd_v);
    chk(rd_v, `SCB_RST_SCR);
    rd(`SCB_A_SIZE, rd_v);
    chk(rd_v, `SCB_RST_SIZE);
    rd(`SCB_A_RXD, rd_v);
    chk(rd_v, `SCB_RST_ZERO);
    rd(`SCB_A_QCTL, rd_v);
    chk(rd_v, `SCB_RST_QCTL);
    rd(32'hFFFFEC8C, rd_v);
    chk(rd_v, 16'h0000);
    wr_back(`SCB_A_WAIT, 16'h5AC3, 16'hFFFF);
    wr(`SCB_A_WAIT, `SCB_RST_ZERO);
    // divisor of every normal case and the extended corners;
    // 25 MHz over a divisor of 2 or more stays in pad limits
    for (i = 0; i < 20; i = i + 1) begin
      cs = i < 16 ? i[4:0] : i == 16 ? 5'h10 : i == 17 ? 5'h18
        : i == 18 ? 5'h1D : 5'h17;
      seed = xs(seed);
      wr_back(`SCB_A_SIZE, {10'h000, cs[3], cs[4], 4'h1}, 16'h003F);
      wr_back(`SCB_A_SCR, {cs[2:0], 13'h0D42}, 16'hFFC0);
      wr(`SCB_A_TXD, seed[15:0]);
      wait_sclk(n);
      wait_sclk(n);
      chk(n[15:0], bd(cs[2:0], cs[4], cs[3]) / 2);
      @(posedge clk_sys);
      ss_n_in <= 1'b0;
      wait_scr(`SCB_F_MODE_FAULT_FLAG, 1'b1);
      chk({15'h0000, sclk_oe_q}, 16'h0000);
      chk({15'h0000, err_irq_q}, 16'h0001);
      @(posedge clk_sys);
      ss_n_in <= 1'b1;
      wr(`SCB_A_QCTL, 16'h0001);
      rd(`SCB_A_RXD, rd_v);
      wr(`SCB_A_SCR, 16'h0828);
      rd(`SCB_A_SCR, rd_v);
      chk({15'h0000, err_irq_q}, 16'h0000);
    end
    // random words of random length in both shift orders
    for (i = 0; i < 8; i = i + 1) begin
      seed = xs(seed);
      w = seed[15:0];
      p_lsb = i[0];
      p_cpha = i[1];
      p_len = i == 2 ? 5'h10 : i == 3 ? 5'h02 : 5'h02 + seed[19:16] % 5'h0F;
      p_tx = seed[31:16] & mk(p_len);
      p_load = ~p_load;
      wr(`SCB_A_SIZE, {12'h000, p_len[3:0] - 4'h1});
      wr_back(`SCB_A_SCR, {3'h0, i[0], 5'h02, i[1], 6'h02}, 16'hFFC0);
      wr(`SCB_A_TXD, w);
      wait_scr(`SCB_F_RXFULL, 1'b1);
      rd(`SCB_A_RXD, rd_v);
      chk(rd_v, p_tx);
      chk(far_rx, w & mk(p_len));
    end
    // fill the queue while stopped, drain it into an overflow
    wr(`SCB_A_SIZE, 16'h0001);
    wr(`SCB_A_SCR, 16'h0940);
    for (i = 0; i < 33; i = i + 1) wr(`SCB_A_TXD, i[15:0]);
    @(negedge clk_sys);
    chk({15'h0000, tx_space_q}, 16'h0000);
    wr(`SCB_A_SCR, 16'h0942);
    wait_scr(`SCB_F_TXEMPTY, 1'b1);
    wait_scr(`SCB_F_BUSY, 1'b0);
    chk({15'h0000, tx_space_q}, 16'h0001);
    chk({15'h0000, err_irq_q}, 16'h0001);
    wr(`SCB_A_SCR, 16'h0948);
    rd(`SCB_A_RXD, rd_v);
    rd(`SCB_A_SCR, rd_v);
    chk({15'h0000, err_irq_q}, 16'h0000);
    final_report;
  end
endmodule // spi_control_baud_select_tb_top
